// File: hw/lcdt_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register address, 16-bit register data
// Notes: Included by the sequencer and top design files of the block
`ifndef LCDT_DEFINES_SVH
`define LCDT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LCDT_OFS_PWR 8'h04
`define LCDT_OFS_VIDEO_MEMORY_CLOCK 8'h06
`define LCDT_OFS_VIDEO_CLOCK 8'h08
`define LCDT_OFS_FMC 8'h0a
`define LCDT_OFS_ADJ 8'h0c
`define LCDT_OFS_HDISP 8'h10
`define LCDT_OFS_HSYNC 8'h12
`define LCDT_OFS_VEND 8'h14
`define LCDT_OFS_VTOT 8'h16
`define LCDT_OFS_VSS 8'h18
`define LCDT_OFS_VSE 8'h1a
`define LCDT_OFS_SAL 8'h1c
`define LCDT_OFS_SAH 8'h1e

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define LCDT_MSK_PWR 16'h003f
`define LCDT_MSK_GATE 16'h0001
`define LCDT_MSK_FMC 16'h1ffb
`define LCDT_MSK_ADJ 16'he7ff
`define LCDT_MSK_FULL 16'hffff
`define LCDT_MSK_LINE 16'h07ff
`define LCDT_MSK_VSE 16'h03ff
`define LCDT_MSK_SAH 16'h73ff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCDT_RST_GATE 16'h0001
`define LCDT_RST_ZERO 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LCDT_PWR_VEE 0
`define LCDT_PWR_PANEL 1
`define LCDT_PWR_VDD 2
`define LCDT_PWR_BL 3
`define LCDT_PWR_PD 4
`define LCDT_PWR_SR 5
`define LCDT_FMC_RC 12
`define LCDT_FMC_CAS_HI 11
`define LCDT_FMC_CAS_LO 10
`define LCDT_FMC_SCROFF 9
`define LCDT_FMC_MEMOFF 8
`define LCDT_FMC_THD_HI 7
`define LCDT_FMC_THD_LO 5
`define LCDT_FMC_CONF_HI 4
`define LCDT_FMC_CONF_LO 3
`define LCDT_FMC_DEP_HI 1
`define LCDT_FMC_DEP_LO 0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define LCDT_RC_SLOW 2'd3
`define LCDT_RC_FAST 2'd2
`define LCDT_CHAR_PIX 8
`define LCDT_PIX_LAST 3'd7
`define LCDT_TAP_PS 1500
`define LCDT_DEP_16 5'd16
`define LCDT_DEP_12 5'd12
`define LCDT_DEP_8 5'd8
`define LCDT_DEP_4 5'd4

`endif

// File: hw/lcdt_pkg.sv
// Purpose: Types shared by the display timing block
// Assumes: Constants come from lcdt_defines.svh
// Notes: Sequencer and top state is held in these structs
package lcdt_pkg;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] pwr;
        logic [15:0] video_memory_clock;
        logic [15:0] video_clock;
        logic [15:0] fmc;
        logic [15:0] adj;
        logic [15:0] hdisp;
        logic [15:0] hsync;
        logic [15:0] vend;
        logic [15:0] vtot;
        logic [15:0] vss;
        logic [15:0] vse;
        logic [15:0] sal;
        logic [15:0] sah;
    } lcdt_regs_t;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } lcdt_bus_req_t;

    // ------------------------------------------------------------
    // DRAM sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LCDT_SQ_IDLE = 2'b00,
        LCDT_SQ_RAS = 2'b01,
        LCDT_SQ_CAS = 2'b10,
        LCDT_SQ_PRE = 2'b11
    } lcdt_seq_e_t;

    typedef struct packed {
        lcdt_seq_e_t state;
        logic [1:0] cnt;
        logic ras_n;
        logic cas_n;
        logic [9:0] addr;
        logic [9:0] col;
    } lcdt_seq_st_t;

    // ------------------------------------------------------------
    // Top state
    // ------------------------------------------------------------
    typedef struct packed {
        lcdt_regs_t regs;
        logic [15:0] rdata;
        logic vsync;
        logic [2:0] skip;
        logic burst;
        logic [4:0] level;
        logic [20:0] line_addr;
        logic [20:0] fetch_addr;
        logic [15:0] word;
        logic lp;
        logic fm;
        logic de;
        logic [15:0] data;
        logic bank;
    } lcdt_state_t;

endpackage

// File: hw/lcdt_wrap_cnt.sv
// Purpose: Counter that wraps to zero after a programmed limit
// Assumes: Limit may change at any time; compare is greater-or-equal
// Notes: Wrap is a one-cycle pulse on the stepping edge
`timescale 1ns/1ps
`default_nettype none
module lcdt_wrap_cnt #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control
    input wire logic step,
    input wire logic clear,
    input wire logic [W-1:0] limit,
    // Count
    output logic [W-1:0] count,
    output logic wrap
);
    import lcdt_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } lcdt_cnt_st_t;

    lcdt_cnt_st_t st_r;
    lcdt_cnt_st_t st_nxt;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        wrap = step && (st_r.cnt >= limit);
        if (clear) begin
            st_nxt.cnt = '0;
        end else if (wrap) begin
            st_nxt.cnt = '0;
        end else if (step) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;
endmodule
`default_nettype wire

// File: hw/lcdt_dram_seq.sv
// Purpose: One read cycle on the frame-buffer DRAM
// Assumes: Memory clock is ref_clk; read data valid while column strobe low
// Notes: Column address is set one cycle before column strobe falls
`timescale 1ns/1ps
`default_nettype none
`include "lcdt_defines.svh"
module lcdt_dram_seq (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Request
    input wire logic start,
    input wire logic row_to_column_select,
    input wire logic [9:0] row,
    input wire logic [9:0] col,
    // Status
    output logic busy,
    output logic done,
    // DRAM strobes
    output logic dram_row_strobe_n,
    output logic dram_column_strobe_n,
    output logic [9:0] dram_addr
);
    import lcdt_pkg::*;

    lcdt_seq_st_t st_r;
    lcdt_seq_st_t st_nxt;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            LCDT_SQ_IDLE: begin
                if (start) begin
                    st_nxt.state = LCDT_SQ_RAS;
                    st_nxt.ras_n = 1'b0;
                    st_nxt.addr = row;
                    st_nxt.col = col;
                    st_nxt.cnt = row_to_column_select ?
                        (`LCDT_RC_FAST - 2'd1) : (`LCDT_RC_SLOW - 2'd1);
                end
            end
            LCDT_SQ_RAS: begin
                if (st_r.cnt == 2'd1) begin
                    st_nxt.addr = st_r.col;
                end
                if (st_r.cnt == 2'd0) begin
                    st_nxt.state = LCDT_SQ_CAS;
                    st_nxt.cas_n = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt - 2'd1;
                end
            end
            LCDT_SQ_CAS: begin
                st_nxt.state = LCDT_SQ_PRE;
                st_nxt.ras_n = 1'b1;
                st_nxt.cas_n = 1'b1;
            end
            LCDT_SQ_PRE: begin
                st_nxt.state = LCDT_SQ_IDLE;
            end
            default: begin
                st_nxt.state = LCDT_SQ_IDLE;
                st_nxt.ras_n = 1'b1;
                st_nxt.cas_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{state: LCDT_SQ_IDLE, cnt: 2'd0, ras_n: 1'b1, cas_n: 1'b1,
                      addr: 10'h000, col: 10'h000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = (st_r.state != LCDT_SQ_IDLE);
    assign done = (st_r.state == LCDT_SQ_CAS);
    assign dram_row_strobe_n = st_r.ras_n;
    assign dram_column_strobe_n = st_r.cas_n;
    assign dram_addr = st_r.addr;
endmodule
`default_nettype wire

// File: hw/lcdt_top.sv
// Purpose: Register-controlled LCD timing, power and frame-fetch core
// Assumes: Video and memory clocks are ref_clk, gated by enable bits
// Notes: DRAM read data is synchronous to the strobes driven here
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcdt_defines.svh"
module lcdt_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire lcdt_pkg::lcdt_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    // Panel type
    input wire logic dual_scan_color,
    // Power and clock gates
    output logic panel_vdd_en,
    output logic panel_vee_en,
    output logic backlight_on,
    output logic power_down_enable,
    output logic self_refresh_enable,
    output logic video_clock_en,
    output logic video_memory_clock_en,
    // Panel signals
    output logic panel_line_pulse,
    output logic panel_frame_marker,
    output logic panel_data_enable,
    output logic [15:0] panel_data,
    // Frame-buffer DRAM
    output logic [9:0] dram_addr,
    output logic [1:0] dram_row_strobe_n,
    output logic [1:0] dram_column_strobe_n,
    output logic [1:0] column_strobe_tuning,
    output logic dram_oe,
    input wire logic [15:0] dram_rdata,
    // Memory configuration
    output logic mem_two_chips,
    output logic mem_large,
    output logic mem_invalid
);
    import lcdt_pkg::*;

    lcdt_state_t st_r;
    lcdt_state_t st_nxt;

    logic [2:0] pix;
    logic pix_wrap;
    logic [7:0] hchar;
    logic hchar_wrap;
    logic [10:0] vline;
    logic vline_wrap;
    logic video_clock_on;
    logic video_memory_clock_on;
    logic seq_start;
    logic seq_busy;
    logic seq_done;
    logic seq_ras_n;
    logic seq_cas_n;
    logic [4:0] depth;
    logic [4:0] empty;
    logic [2:0] threshold;
    logic [1:0] conf;
    logic h_active;
    logic v_active;
    logic hsync_win;
    logic line_end;
    logic consume;
    logic fill;
    logic [20:0] frame_start;
    logic [20:0] line_step;
    logic mem_ok;

    // --------------------------------------------------------------
    // Field decode
    // --------------------------------------------------------------
    assign video_memory_clock_on = st_r.regs.video_memory_clock[0];
    assign video_clock_on = st_r.regs.video_clock[0];
    assign threshold = st_r.regs.fmc[`LCDT_FMC_THD_HI:`LCDT_FMC_THD_LO];
    assign conf = st_r.regs.fmc[`LCDT_FMC_CONF_HI:`LCDT_FMC_CONF_LO];
    assign mem_two_chips = (conf == 2'b10);
    assign mem_large = (conf == 2'b01);
    assign mem_invalid = (conf == 2'b11);
    assign mem_ok = !mem_invalid && video_memory_clock_on && !st_r.regs.fmc[`LCDT_FMC_MEMOFF];
    assign frame_start = {st_r.regs.sah[14:12], st_r.regs.sal, 2'b00};
    assign line_step = {8'h00, st_r.regs.sah[9:0], 3'b000};

    always_comb begin
        case (st_r.regs.fmc[`LCDT_FMC_DEP_HI:`LCDT_FMC_DEP_LO])
            2'b00: depth = `LCDT_DEP_16;
            2'b01: depth = `LCDT_DEP_12;
            2'b10: depth = `LCDT_DEP_8;
            default: depth = `LCDT_DEP_4;
        endcase
    end

    // --------------------------------------------------------------
    // Timing counters
    // --------------------------------------------------------------
    lcdt_wrap_cnt #(.W(3)) u_pix (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .step(video_clock_on),
        .clear(1'b0),
        .limit(`LCDT_PIX_LAST),
        .count(pix),
        .wrap(pix_wrap)
    );

    lcdt_wrap_cnt #(.W(8)) u_hchar (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .step(pix_wrap),
        .clear(1'b0),
        .limit(st_r.regs.hdisp[7:0]),
        .count(hchar),
        .wrap(hchar_wrap)
    );

    lcdt_wrap_cnt #(.W(11)) u_vline (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .step(hchar_wrap),
        .clear(1'b0),
        .limit(st_r.regs.vtot[10:0]),
        .count(vline),
        .wrap(vline_wrap)
    );

    assign line_end = hchar_wrap;
    assign h_active = (hchar <= st_r.regs.hdisp[15:8]);
    assign v_active = (vline <= st_r.regs.vend[10:0]);
    assign hsync_win = (hchar >= st_r.regs.hsync[7:0]) &&
        (hchar < st_r.regs.hsync[15:8]);

    // --------------------------------------------------------------
    // Fetch buffer occupancy
    // --------------------------------------------------------------
    assign empty = (depth > st_r.level) ? (depth - st_r.level) : 5'd0;
    assign consume = pix_wrap && h_active && v_active && (st_r.level != 5'd0);
    assign fill = seq_done;
    assign seq_start = mem_ok && !seq_busy && !line_end &&
        (st_r.burst ? (st_r.level < depth) : (empty > {2'b00, threshold}));

    lcdt_dram_seq u_seq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(seq_start),
        .row_to_column_select(st_r.regs.fmc[`LCDT_FMC_RC]),
        .row(st_r.fetch_addr[20:11]),
        .col(st_r.fetch_addr[10:1]),
        .busy(seq_busy),
        .done(seq_done),
        .dram_row_strobe_n(seq_ras_n),
        .dram_column_strobe_n(seq_cas_n),
        .dram_addr(dram_addr)
    );

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                `LCDT_OFS_PWR: st_nxt.regs.pwr = bus_req.wdata & `LCDT_MSK_PWR;
                `LCDT_OFS_VIDEO_MEMORY_CLOCK: st_nxt.regs.video_memory_clock = bus_req.wdata & `LCDT_MSK_GATE;
                `LCDT_OFS_VIDEO_CLOCK: st_nxt.regs.video_clock = bus_req.wdata & `LCDT_MSK_GATE;
                `LCDT_OFS_FMC: st_nxt.regs.fmc = bus_req.wdata & `LCDT_MSK_FMC;
                `LCDT_OFS_ADJ: st_nxt.regs.adj = bus_req.wdata & `LCDT_MSK_ADJ;
                `LCDT_OFS_HDISP: st_nxt.regs.hdisp = bus_req.wdata & `LCDT_MSK_FULL;
                `LCDT_OFS_HSYNC: st_nxt.regs.hsync = bus_req.wdata & `LCDT_MSK_FULL;
                `LCDT_OFS_VEND: st_nxt.regs.vend = bus_req.wdata & `LCDT_MSK_LINE;
                `LCDT_OFS_VTOT: st_nxt.regs.vtot = bus_req.wdata & `LCDT_MSK_LINE;
                `LCDT_OFS_VSS: st_nxt.regs.vss = bus_req.wdata & `LCDT_MSK_LINE;
                `LCDT_OFS_VSE: st_nxt.regs.vse = bus_req.wdata & `LCDT_MSK_VSE;
                `LCDT_OFS_SAL: st_nxt.regs.sal = bus_req.wdata & `LCDT_MSK_FULL;
                `LCDT_OFS_SAH: st_nxt.regs.sah = bus_req.wdata & `LCDT_MSK_SAH;
                default: st_nxt.regs = st_r.regs;
            endcase
        end
        // Register reads
        if (bus_req.rd) begin
            case (bus_req.addr)
                `LCDT_OFS_PWR: st_nxt.rdata = st_r.regs.pwr;
                `LCDT_OFS_VIDEO_MEMORY_CLOCK: st_nxt.rdata = st_r.regs.video_memory_clock;
                `LCDT_OFS_VIDEO_CLOCK: st_nxt.rdata = st_r.regs.video_clock;
                `LCDT_OFS_FMC: st_nxt.rdata = st_r.regs.fmc;
                `LCDT_OFS_ADJ: st_nxt.rdata = st_r.regs.adj;
                `LCDT_OFS_HDISP: st_nxt.rdata = st_r.regs.hdisp;
                `LCDT_OFS_HSYNC: st_nxt.rdata = st_r.regs.hsync;
                `LCDT_OFS_VEND: st_nxt.rdata = st_r.regs.vend;
                `LCDT_OFS_VTOT: st_nxt.rdata = st_r.regs.vtot;
                `LCDT_OFS_VSS: st_nxt.rdata = st_r.regs.vss;
                `LCDT_OFS_VSE: st_nxt.rdata = st_r.regs.vse;
                `LCDT_OFS_SAL: st_nxt.rdata = st_r.regs.sal;
                `LCDT_OFS_SAH: st_nxt.rdata = st_r.regs.sah;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end else begin
            st_nxt.rdata = 16'h0000;
        end

        // Vertical sync window
        if (line_end && (vline == st_r.regs.vss[10:0])) begin
            st_nxt.vsync = 1'b1;
        end else if (line_end && (vline[3:0] == st_r.regs.vse[3:0])) begin
            st_nxt.vsync = 1'b0;
        end

        // Line pulse skipping at mid-frame and frame end
        if (line_end && dual_scan_color &&
                (vline == st_r.regs.adj[10:0])) begin
            st_nxt.skip = st_r.regs.vse[6:4];
        end else if (vline_wrap && dual_scan_color) begin
            st_nxt.skip = st_r.regs.vse[9:7];
        end else if (line_end && (st_r.skip != 3'd0)) begin
            st_nxt.skip = st_r.skip - 3'd1;
        end

        // Buffer level, burst and fetch address
        if (fill) begin
            st_nxt.word = dram_rdata;
            st_nxt.fetch_addr = st_r.fetch_addr + 21'd2;
        end
        if (fill && !consume) begin
            st_nxt.level = st_r.level + 5'd1;
        end else if (consume && !fill) begin
            st_nxt.level = st_r.level - 5'd1;
        end
        if (seq_start) begin
            st_nxt.burst = 1'b1;
        end else if (st_r.level >= depth) begin
            st_nxt.burst = 1'b0;
        end
        if (vline_wrap) begin
            st_nxt.line_addr = frame_start;
            st_nxt.fetch_addr = frame_start;
            st_nxt.level = 5'd0;
            st_nxt.burst = 1'b0;
        end else if (line_end && v_active) begin
            st_nxt.line_addr = st_r.line_addr + line_step;
            st_nxt.fetch_addr = st_r.line_addr + line_step;
            st_nxt.level = 5'd0;
            st_nxt.burst = 1'b0;
        end

        // Panel outputs
        st_nxt.lp = st_r.regs.pwr[`LCDT_PWR_PANEL] && hsync_win &&
            (st_r.skip == 3'd0);
        st_nxt.fm = st_r.regs.pwr[`LCDT_PWR_PANEL] && st_r.vsync;
        st_nxt.de = st_r.regs.pwr[`LCDT_PWR_PANEL] && video_clock_on && h_active && v_active &&
            !st_r.regs.fmc[`LCDT_FMC_SCROFF] &&
            !((hchar == 8'h00) && (pix < st_r.regs.adj[15:13]));
        st_nxt.data = st_nxt.de ? st_r.word : 16'h0000;
        if (seq_start) begin
            st_nxt.bank = mem_two_chips ? st_r.fetch_addr[20] : 1'b0;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.regs.video_memory_clock <= `LCDT_RST_GATE;
            st_r.regs.video_clock <= `LCDT_RST_GATE;
            st_r.regs.fmc <= `LCDT_RST_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign bus_rdata = st_r.rdata;
    assign panel_vdd_en = st_r.regs.pwr[`LCDT_PWR_VDD];
    assign panel_vee_en = st_r.regs.pwr[`LCDT_PWR_VEE];
    assign backlight_on = st_r.regs.pwr[`LCDT_PWR_BL] && st_r.regs.pwr[`LCDT_PWR_VEE];
    assign power_down_enable = st_r.regs.pwr[`LCDT_PWR_PD];
    assign self_refresh_enable = st_r.regs.pwr[`LCDT_PWR_SR];
    assign video_clock_en = video_clock_on;
    assign video_memory_clock_en = video_memory_clock_on;
    assign panel_line_pulse = st_r.lp;
    assign panel_frame_marker = st_r.fm;
    assign panel_data_enable = st_r.de;
    assign panel_data = st_r.data;
    assign column_strobe_tuning = st_r.regs.fmc[`LCDT_FMC_CAS_HI:`LCDT_FMC_CAS_LO];
    assign dram_row_strobe_n = st_r.bank ? {seq_ras_n, 1'b1} : {1'b1, seq_ras_n};
    assign dram_column_strobe_n = st_r.bank ? {seq_cas_n, 1'b1} : {1'b1, seq_cas_n};
    assign dram_oe = !st_r.regs.fmc[`LCDT_FMC_MEMOFF];
endmodule
`default_nettype wire

// File: test/lcdt_dram_model.sv
// Purpose: Frame-buffer DRAM stand-in
// Assumes: Data valid while column strobe is low
// Notes: Otherwise the data bus toggles each cycle
`timescale 1ns/1ps
`default_nettype none
module lcdt_dram_model (
    // Strobes and address
    input wire logic ref_clk,
    input wire logic [9:0] dram_addr,
    input wire logic [1:0] dram_column_strobe_n,
    // Read data
    output logic [15:0] dram_rdata
);
    logic [15:0] junk = 16'h5a5a;
    always @(posedge ref_clk) junk <= ~junk;
    assign dram_rdata = &dram_column_strobe_n ? junk : {6'h2a, dram_addr};
endmodule
`default_nettype wire

// File: test/lcdt_monitor.sv
// Purpose: Assertions on lcdt_top ports
// Assumes: One clock, async active-low reset
// Notes: Bound into every lcdt_top
`timescale 1ns/1ps
`default_nettype none
module lcdt_monitor (
    // Clock, reset, bus
    input wire logic ref_clk,
    input wire logic resetn,
    input wire lcdt_pkg::lcdt_bus_req_t bus_req,
    // Watched outputs
    input wire logic panel_vee_en,
    input wire logic backlight_on,
    input wire logic video_clock_en,
    input wire logic video_memory_clock_en,
    input wire logic panel_line_pulse,
    input wire logic dram_oe,
    input wire logic [1:0] column_strobe_tuning,
    input wire logic [1:0] dram_row_strobe_n,
    input wire logic [1:0] dram_column_strobe_n
);
    import lcdt_pkg::*;
    logic [7:0] wr_a;
    assign wr_a = bus_req.wr ? bus_req.addr : 8'hff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence ras_fall;
        $fell(dram_row_strobe_n[0]);
    endsequence
    sequence cas_fall;
        ##[2:3] $fell(dram_column_strobe_n[0]);
    endsequence
    AST_BL: assert property (backlight_on |-> panel_vee_en)
        else $error("backlight without bias");
    AST_RC: assert property (ras_fall |-> cas_fall)
        else $error("row to column delay");
    AST_CAS: assert property ($fell(dram_column_strobe_n[0]) |=>
        dram_row_strobe_n[0] && dram_column_strobe_n[0])
        else $error("column strobe width");
    AST_VM: assert property ($changed(video_memory_clock_en) |-> $past(wr_a) == 8'h06)
        else $error("memory clock gate");
    AST_VC: assert property ($changed(video_clock_en) |-> $past(wr_a) == 8'h08)
        else $error("video clock gate");
    AST_OE: assert property ($changed(dram_oe) |-> $past(wr_a) == 8'h0a)
        else $error("dram drive change");
    AST_TUNE: assert property ($changed(column_strobe_tuning) |-> $past(wr_a) == 8'h0a)
        else $error("tuning change");
    AST_LP: assert property ($rose(panel_line_pulse) |->
        (panel_line_pulse || $past(bus_req.wr, 2))[*8]) else $error("line pulse width");
endmodule
bind lcdt_top lcdt_monitor mon (.ref_clk, .resetn, .bus_req, .panel_vee_en, .backlight_on,
    .video_clock_en, .video_memory_clock_en, .panel_line_pulse, .dram_oe,
    .column_strobe_tuning, .dram_row_strobe_n, .dram_column_strobe_n);
`default_nettype wire

// File: test/lcdt_top_tb.sv
// Purpose: Self-checking bench for lcdt_top
// Assumes: Register model and frame totals worked out here
// Notes: Timing counted over one whole frame
`timescale 1ns/1ps
`default_nettype none
module lcdt_top_tb;
    import lcdt_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic dual_scan_color = 1'b0;
    lcdt_bus_req_t bus_req = '0;
    logic [15:0] bus_rdata, panel_data, dram_rdata;
    logic [9:0] dram_addr;
    logic [1:0] dram_row_strobe_n, dram_column_strobe_n, column_strobe_tuning;
    logic panel_vdd_en, panel_vee_en, backlight_on, power_down_enable, self_refresh_enable;
    logic video_clock_en, video_memory_clock_en, panel_line_pulse, panel_frame_marker;
    logic panel_data_enable, dram_oe, mem_two_chips, mem_large, mem_invalid;
    int n_fail = 0, comparisons = 0, cyc = 0;
    int t [6];
    logic [31:0] rnd = 32'd57;
    logic [15:0] exp_r [int];
    logic [15:0] msk [int] = '{8'h04: 16'h3f, 8'h06: 16'h1, 8'h08: 16'h1, 8'h0a: 16'h1ffb,
        8'h0c: 16'he7ff, 8'h10: 16'hffff, 8'h12: 16'hffff, 8'h14: 16'h7ff, 8'h16: 16'h7ff,
        8'h18: 16'h7ff, 8'h1a: 16'h3ff, 8'h1c: 16'hffff, 8'h1e: 16'h73ff};
    logic [15:0] pseq [11] = '{16'h0, 16'h4, 16'h6, 16'h7, 16'hf, 16'h38, 16'hf, 16'h7,
        16'h6, 16'h4, 16'h0};
    logic [15:0] rows [4][8] = '{
        '{16'h7, 16'h2, 16'h5, 16'h0, 16'h0, 16'h30, 16'h50, 16'hc0},
        '{16'h5, 16'h2, 16'h5, 16'h1000, 16'h0, 16'h0, 16'h0, 16'h0},
        '{16'h7, 16'h2, 16'h5, 16'h200, 16'h0, 16'h30, 16'h50, 16'h0},
        '{16'h7, 16'h6002, 16'h95, 16'h1000, 16'h1, 16'h20, 16'h50, 16'hb4}};
    lcdt_top uut (.*);
    lcdt_dram_model dram (.*);
    initial forever #5 ref_clk = ~ref_clk;
    function automatic logic [15:0] rand16();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[15:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
        if (msk.exists(a)) exp_r[a] = d & msk[a];
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        bus_req <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 chk(bus_rdata, exp_r.exists(a) ? exp_r[a] : 16'h0);
        @(posedge ref_clk);
    endtask
    task automatic rst();
        resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (msk[a]) exp_r[a] = (a == 6 || a == 8) ? 16'h1 : 16'h0;
        @(posedge ref_clk);
    endtask
    task automatic conclude();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        rst();
        foreach (msk[a]) rd(a[7:0]);
        rd(8'h02);
        foreach (msk[a]) wr(a[7:0], rand16());
        wr(8'h20, rand16());
        foreach (msk[a]) rd(a[7:0]);
        foreach (pseq[i]) begin
            wr(8'h04, pseq[i]);
            chk({backlight_on, panel_vdd_en, panel_vee_en, power_down_enable, self_refresh_enable},
                {pseq[i][3] & pseq[i][0], pseq[i][2], pseq[i][0], pseq[i][4], pseq[i][5]});
        end
        for (int g = 0; g < 2; g++) begin
            wr(8'h06, 16'(g));
            wr(8'h08, 16'(g));
            chk({video_memory_clock_en, video_clock_en}, {2{g[0]}});
        end
        for (int i = 0; i < 32; i++) begin
            wr(8'h0a, {4'h0, i[3:2], 1'b0, i[4], 3'h0, i[1:0], 3'h0});
            chk({mem_two_chips, mem_large, mem_invalid, column_strobe_tuning, dram_oe},
                {i[1:0] == 2'b10, i[1:0] == 2'b01, &i[1:0], i[3:2], !i[4]});
        end
        rst();
        wr(8'h10, 16'h509);
        wr(8'h12, 16'h807);
        wr(8'h14, 16'h3);
        wr(8'h16, 16'h5);
        wr(8'h18, 16'h4);
        foreach (rows[r]) begin
            wr(8'h04, rows[r][0]);
            wr(8'h0c, rows[r][1]);
            wr(8'h1a, rows[r][2]);
            wr(8'h0a, rows[r][3]);
            dual_scan_color <= rows[r][4][0];
            repeat (1000) @(posedge ref_clk);
            t = '{default: 0};
            repeat (480) begin
                @(negedge ref_clk);
                t[0] += panel_line_pulse;
                t[1] += panel_frame_marker;
                t[2] += panel_data_enable;
                t[3] += !dram_row_strobe_n[0] && dram_column_strobe_n[0];
                t[4] += !dram_column_strobe_n[0];
                t[5] += panel_data !== (panel_data_enable ? {6'h2a, panel_data[9:0]} : 16'h0);
            end
            @(posedge ref_clk);
            chk(16'(t[5]), 16'h0);
            chk(16'(t[0]), rows[r][5]);
            chk(16'(t[1]), rows[r][6]);
            chk(16'(t[2]), rows[r][7]);
            chk(16'(t[4] > 0 ? (t[3] + t[4] / 2) / t[4] : 0), rows[r][3][12] ? 16'h2 : 16'h3);
        end
        conclude();
    end
endmodule
`default_nettype wire
